/* hw/cecfg_consts.svh */
// offsets, field positions, reset values and timing counts of the engine configuration bank
`ifndef CECFG_CONSTS_SVH
`define CECFG_CONSTS_SVH
`define CECFG_ADDR_TSEL 16'h2000
`define CECFG_ADDR_SUM 16'h2001
`define CECFG_ADDR_STAT 16'h2002
`define CECFG_ADDR_REF 16'h2004
`define CECFG_ADDR_RSVD 16'h2005
`define CECFG_ADDR_REV 16'h2006
`define CECFG_ADDR_SSCTL 16'h2070
`define CECFG_ADDR_SSBEG 16'h2071
`define CECFG_ADDR_SSEND 16'h2072
`define CECFG_ADDR_FSEL 16'h20fd
`define CECFG_ADDR_FUSE 16'h20ff
`define CECFG_ADDR_WDCTL 8'he8
`define CECFG_CE_BASE 16'h1000
`define CECFG_CE_LAST 16'h13ff
`define CECFG_ACC_WORD 8'h24
`define CECFG_BIT_WDRST 7
`define CECFG_BIT_WDOVF 2
`define CECFG_BIT_RTMEN 3
`define CECFG_BIT_REFCAL 7
`define CECFG_BIT_REFDIS 3
`define CECFG_BIT_SSEN 7
`define CECFG_BIT_SS10M 6
`define CECFG_FSEL_TRIM 8'h04
`define CECFG_FSEL_BGA 8'h05
`define CECFG_FSEL_BGB 8'h06
`define CECFG_RST_TSEL 4'h0
`define CECFG_RST_SUM 8'h00
`define CECFG_RST_BYTE 8'h00
`define CECFG_REVISION 8'h5a // arbitrary value
`define CECFG_BASE_HZ 32768
`define CECFG_MUX_PERIODS 13
`define CECFG_CONV_PERIODS 12
`define CECFG_CONV_BASE 2
`define CECFG_CONV_PER_MUX 6
`endif

/* hw/cecfg_pkg.sv */
// types shared by the engine configuration bank
package cecfg_pkg;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cecfg_xram_req_t;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cecfg_sfr_req_t;
   typedef struct packed {
      logic ce_word_wr;
      logic [7:0] ce_word_addr;
      logic [31:0] ce_word_data;
   } cecfg_ce_wr_t;
   typedef struct packed {
      logic realtime_monitor_out;
      logic mux_sync;
      logic ten_mhz_clock;
      logic processor_clock;
      logic rtc_tick_clock;
      logic ce_busy;
      logic transfer_busy_event;
      logic [6:0] misc;
   } cecfg_tsrc_t;
   typedef enum logic [1:0] {
      CECFG_SS_IDLE = 2'b00,
      CECFG_SS_SEND = 2'b01,
      CECFG_SS_DONE = 2'b10
   } cecfg_ss_state_t;
endpackage : cecfg_pkg

/* hw/cecfg_ce_port.sv */
// byte-lane mapping of 32-bit engine words into processor space
`timescale 1ns/1ps
`include "cecfg_consts.svh"
module cecfg_ce_port
   import cecfg_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire cecfg_xram_req_t req,
   input wire logic [15:0] acc_count,
   input wire logic acc_upd,
   output cecfg_ce_wr_t ce_wr,
   output logic hit
);
   logic [15:0] off;
   logic [7:0] word_idx;
   logic [1:0] lane;
   logic [31:0] word_q;
   assign off = req.addr - `CECFG_CE_BASE;
   assign word_idx = off[9:2];
   assign lane = off[1:0];
   assign hit = (req.addr >= `CECFG_CE_BASE) && (req.addr <= `CECFG_CE_LAST);
   // lane 0 is the msb, lane 3 the lsb; word committed on the lsb write
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         word_q <= 32'h0000_0000;
         ce_wr <= '0;
      end else begin
         ce_wr.ce_word_wr <= 1'b0;
         if (req.wr && hit) begin // see RULE15
            case (lane)
               2'd0: word_q[31:24] <= req.wdata;
               2'd1: word_q[23:16] <= req.wdata;
               2'd2: word_q[15:8] <= req.wdata;
               default: begin
                  ce_wr.ce_word_wr <= 1'b1; // see RULE14
                  ce_wr.ce_word_addr <= word_idx;
                  ce_wr.ce_word_data <= {word_q[31:8], req.wdata};
               end
            endcase
         end else if (acc_upd) begin
            ce_wr.ce_word_wr <= 1'b1; // see RULE17
            ce_wr.ce_word_addr <= `CECFG_ACC_WORD;
            ce_wr.ce_word_data <= {16'h0000, acc_count};
         end
      end
   end
   AST_CE_LSB_COMMIT: assert property (@(posedge clock) disable iff (!arst_n)
      (req.wr && hit && lane == 2'd3) |=> (ce_wr.ce_word_wr && ce_wr.ce_word_addr == $past(word_idx)))
      else $error("lsb write did not commit engine word"); // see RULE15
   AST_CE_NO_PARTIAL: assert property (@(posedge clock) disable iff (!arst_n)
      (req.wr && hit && lane != 2'd3) |=> !ce_wr.ce_word_wr)
      else $error("partial word committed early"); // see RULE14
endmodule : cecfg_ce_port

/* hw/cecfg_bank.sv */
// engine configuration and status register bank
`timescale 1ns/1ps
`include "cecfg_consts.svh"
// Operation
// RULE1: serial block runs start through end address; the code starts a block only when end exceeds start
// RULE2: samples equal pre-sample times sum cycles
// RULE3: four-bit selector routes sixteen test sources; the code routes eleven, codes 0 to 3 and 12 read low
// RULE4: fuse select 4,5,6 picks fuse value
// RULE5: fuse readout returns last selected fuse
// RULE6: read-only eight-bit silicon revision
// RULE7: calibration bit routes reference unless disabled
// RULE8: disable bit turns reference off
// RULE9: writing one restarts watchdog count
// RULE10: software writes watchdog byte whole only
// RULE11: overflow flag set on overflow, retained
// RULE12: boot software clears overflow flag
// RULE13: external reset low clears overflow flag
// RULE14: engine words are four-byte two's complement
// RULE15: word n msb at 0x1000 plus 4n
// RULE16: software loads calibration before engine enable
// RULE17: accumulation count mirrored at engine word 36
// RULE18: software prepares environment before engine enable
// RULE19: mux cycle thirteen base periods, twelve converting
// RULE20: default two periods per conversion, six conversions
// RULE21: serial enable switches four segment pins; the code switches the fourth only when ssctl_q[1] is also set
// RULE22: configuration fields hold value until rewritten
module cecfg_bank
   import cecfg_pkg::*;
(
   input wire logic clock,
   input wire logic arst_n,
   input wire logic external_reset_n,
   input wire cecfg_xram_req_t xreq,
   input wire cecfg_sfr_req_t sreq,
   input wire logic watchdog_overflow,
   input wire logic battery_flag_in,
   input wire cecfg_tsrc_t tsrc,
   input wire logic [2:0] three_bit_fuse,
   input wire logic bandgap_fuse_a,
   input wire logic bandgap_fuse_b,
   input wire logic ss_word_done,
   input wire logic base_tick,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic test_output_pin,
   output logic reference_enable,
   output logic reference_to_pin_out,
   output logic watchdog_restart,
   output logic battery_flag_out,
   output logic [3:0] seg_serial_mode,
   output logic ss_active,
   output logic [7:0] ss_word_addr,
   output logic serial_clock_speed_sel,
   output logic conv_strobe,
   output logic mux_cycle_start,
   output cecfg_ce_wr_t ce_wr,
   output logic is_high_accuracy
);
   logic [3:0] test_output_select_q;
   logic [7:0] sum_reg_q;
   logic [7:0] stat_q;
   logic watchdog_overflow_flag_q;
   logic [7:0] ref_q;
   logic [7:0] ssctl_q;
   logic [7:0] serial_block_start_addr_q;
   logic [7:0] serial_block_end_addr_q;
   logic [7:0] fuse_select_q;
   logic [7:0] fuse_readout_d;
   logic [7:0] rdata_d;
   logic [15:0] acc_count_q;
   logic acc_pend_q;
   logic acc_upd_q;
   logic boot_q;
   logic ce_hit;
   logic [15:0] pre_sample_value;
   logic [15:0] acc_product;
   cecfg_ss_state_t ss_state_q;
   logic [3:0] base_cnt_q;
   logic [1:0] conv_cnt_q;
   logic [15:0] tsel;

   function automatic logic wr_at(input logic [15:0] a);
      wr_at = xreq.wr && (xreq.addr == a);
   endfunction : wr_at

   // configuration registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         test_output_select_q <= `CECFG_RST_TSEL;
         sum_reg_q <= `CECFG_RST_SUM;
         stat_q <= `CECFG_RST_BYTE;
         ref_q <= `CECFG_RST_BYTE;
         ssctl_q <= `CECFG_RST_BYTE;
         serial_block_start_addr_q <= `CECFG_RST_BYTE;
         serial_block_end_addr_q <= `CECFG_RST_BYTE;
         fuse_select_q <= `CECFG_RST_BYTE;
      end else begin
         if (wr_at(`CECFG_ADDR_TSEL)) test_output_select_q <= xreq.wdata[3:0]; // see RULE22
         if (wr_at(`CECFG_ADDR_SUM)) sum_reg_q <= xreq.wdata; // see RULE2
         if (wr_at(`CECFG_ADDR_STAT)) stat_q <= xreq.wdata;
         if (wr_at(`CECFG_ADDR_REF)) ref_q <= xreq.wdata;
         if (wr_at(`CECFG_ADDR_SSCTL)) ssctl_q <= xreq.wdata; // see RULE21
         if (wr_at(`CECFG_ADDR_SSBEG)) serial_block_start_addr_q <= xreq.wdata; // see RULE1
         if (wr_at(`CECFG_ADDR_SSEND)) serial_block_end_addr_q <= xreq.wdata; // see RULE1
         if (wr_at(`CECFG_ADDR_FSEL)) fuse_select_q <= xreq.wdata; // see RULE4
      end
   end

   // overflow flag: cleared by external reset, set beats software clear
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         watchdog_overflow_flag_q <= 1'b0;
         battery_flag_out <= 1'b0;
         boot_q <= 1'b0;
      end else begin
         boot_q <= 1'b1;
         if (!external_reset_n) begin
            watchdog_overflow_flag_q <= 1'b0; // see RULE13
         end else if (watchdog_overflow) begin
            watchdog_overflow_flag_q <= 1'b1; // see RULE11
         end else if (wr_at(`CECFG_ADDR_STAT)) begin
            watchdog_overflow_flag_q <= xreq.wdata[`CECFG_BIT_WDOVF]; // see RULE12
         end else if (!boot_q) begin
            // retained level loaded once, on the first edge after reset
            watchdog_overflow_flag_q <= battery_flag_in; // see RULE11
         end
         battery_flag_out <= watchdog_overflow_flag_q;
      end
   end

   // watchdog restart from whole-byte sfr write
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         watchdog_restart <= 1'b0;
      end else begin
         watchdog_restart <= sreq.wr && (sreq.addr == `CECFG_ADDR_WDCTL)
                             && sreq.wdata[`CECFG_BIT_WDRST]; // see RULE9
      end
   end

   // fuse readout mux
   always_comb begin
      case (fuse_select_q)
         `CECFG_FSEL_TRIM: fuse_readout_d = {5'h00, three_bit_fuse}; // see RULE5
         `CECFG_FSEL_BGA: fuse_readout_d = {7'h00, bandgap_fuse_a};
         `CECFG_FSEL_BGB: fuse_readout_d = {7'h00, bandgap_fuse_b};
         default: fuse_readout_d = 8'h00;
      endcase
   end

   // read data
   always_comb begin
      case (xreq.addr)
         `CECFG_ADDR_TSEL: rdata_d = {4'h0, test_output_select_q};
         `CECFG_ADDR_SUM: rdata_d = sum_reg_q;
         `CECFG_ADDR_STAT: rdata_d = {stat_q[7:3], watchdog_overflow_flag_q, stat_q[1:0]};
         `CECFG_ADDR_REF: rdata_d = ref_q;
         `CECFG_ADDR_RSVD: rdata_d = 8'h00;
         `CECFG_ADDR_REV: rdata_d = `CECFG_REVISION; // see RULE6
         `CECFG_ADDR_SSCTL: rdata_d = ssctl_q;
         `CECFG_ADDR_SSBEG: rdata_d = serial_block_start_addr_q;
         `CECFG_ADDR_SSEND: rdata_d = serial_block_end_addr_q;
         `CECFG_ADDR_FUSE: rdata_d = fuse_readout_d; // see RULE5
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 8'h00;
         rvalid <= 1'b0;
      end else begin
         rdata <= rdata_d; // see RULE22
         rvalid <= xreq.rd;
      end
   end

   // test output selector; analog and reserved codes read low
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_tsel
         if (gi == 4) assign tsel[gi] = tsrc.realtime_monitor_out;
         else if (gi == 9) assign tsel[gi] = tsrc.mux_sync;
         else if (gi == 10) assign tsel[gi] = tsrc.ten_mhz_clock;
         else if (gi == 11) assign tsel[gi] = tsrc.processor_clock;
         else if (gi == 13) assign tsel[gi] = tsrc.rtc_tick_clock;
         else if (gi == 14) assign tsel[gi] = tsrc.ce_busy;
         else if (gi == 15) assign tsel[gi] = tsrc.transfer_busy_event;
         else if (gi >= 5 && gi <= 8) assign tsel[gi] = tsrc.misc[gi-5];
         else assign tsel[gi] = 1'b0;
      end
   endgenerate

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         test_output_pin <= 1'b0;
      end else begin
         test_output_pin <= tsel[test_output_select_q]; // see RULE3
      end
   end

   // reference control
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         reference_enable <= 1'b0;
         reference_to_pin_out <= 1'b0;
         is_high_accuracy <= 1'b0;
      end else begin
         reference_enable <= !ref_q[`CECFG_BIT_REFDIS]; // see RULE8
         reference_to_pin_out <= ref_q[`CECFG_BIT_REFCAL]
                                 && !ref_q[`CECFG_BIT_REFDIS]; // see RULE7
         is_high_accuracy <= bandgap_fuse_b; // see RULE5
      end
   end

   // accumulation count, mirrored into engine word two cycles after each sum register write, unless an engine-space write takes that cycle
   assign pre_sample_value = (sum_reg_q[7:6] == 2'd0) ? 16'd42 :
                             (sum_reg_q[7:6] == 2'd1) ? 16'd50 :
                             (sum_reg_q[7:6] == 2'd2) ? 16'd84 : 16'd100;
   assign acc_product = 16'(pre_sample_value * {10'h000, sum_reg_q[5:0]});
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         acc_count_q <= 16'h0000;
         acc_pend_q <= 1'b0;
         acc_upd_q <= 1'b0;
      end else begin
         // extra stage so the mirror carries the product of the new value
         acc_pend_q <= wr_at(`CECFG_ADDR_SUM);
         acc_upd_q <= acc_pend_q;
         acc_count_q <= acc_product; // see RULE2
      end
   end

   // serial transfer block walk
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ss_state_q <= CECFG_SS_IDLE;
         ss_word_addr <= 8'h00;
         ss_active <= 1'b0;
         seg_serial_mode <= 4'h0;
         serial_clock_speed_sel <= 1'b0;
      end else begin
         seg_serial_mode <= {4{ssctl_q[`CECFG_BIT_SSEN]}} & {ssctl_q[1], 3'b111}; // see RULE21
         serial_clock_speed_sel <= ssctl_q[`CECFG_BIT_SS10M];
         case (ss_state_q)
            CECFG_SS_IDLE: begin
               if (ssctl_q[`CECFG_BIT_SSEN] && tsrc.ce_busy
                   && serial_block_end_addr_q > serial_block_start_addr_q) begin // see RULE1
                  ss_state_q <= CECFG_SS_SEND;
                  ss_word_addr <= serial_block_start_addr_q;
                  ss_active <= 1'b1;
               end
            end
            CECFG_SS_SEND: begin
               if (ss_word_done) begin
                  if (ss_word_addr == serial_block_end_addr_q) begin
                     ss_state_q <= CECFG_SS_DONE;
                     ss_active <= 1'b0;
                  end else begin
                     ss_word_addr <= ss_word_addr + 8'h01;
                  end
               end
            end
            CECFG_SS_DONE: begin
               if (!tsrc.ce_busy) ss_state_q <= CECFG_SS_IDLE;
            end
            default: ss_state_q <= CECFG_SS_IDLE;
         endcase
      end
   end

   // mux cycle timing on the 32768 Hz base
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         base_cnt_q <= 4'h0;
         conv_cnt_q <= 2'd0;
         conv_strobe <= 1'b0;
         mux_cycle_start <= 1'b0;
      end else begin
         conv_strobe <= 1'b0;
         mux_cycle_start <= 1'b0;
         if (base_tick) begin
            if (base_cnt_q == 4'(`CECFG_MUX_PERIODS - 1)) begin // see RULE19
               base_cnt_q <= 4'h0;
               conv_cnt_q <= 2'd0;
               mux_cycle_start <= 1'b1;
            end else begin
               base_cnt_q <= base_cnt_q + 4'h1;
               if (base_cnt_q < 4'(`CECFG_CONV_PERIODS)) begin
                  if (conv_cnt_q == 2'(`CECFG_CONV_BASE - 1)) begin // see RULE20
                     conv_cnt_q <= 2'd0;
                     conv_strobe <= 1'b1;
                  end else begin
                     conv_cnt_q <= conv_cnt_q + 2'd1;
                  end
               end
            end
         end
      end
   end

   cecfg_ce_port u_ce_port (
      .clock(clock),
      .arst_n(arst_n),
      .req(xreq),
      .acc_count(acc_count_q),
      .acc_upd(acc_upd_q),
      .ce_wr(ce_wr),
      .hit(ce_hit)
   );

   AST_REF_PIN: assert property (@(posedge clock) disable iff (!arst_n)
      ref_q[`CECFG_BIT_REFDIS] |=> !reference_to_pin_out)
      else $error("reference reached pin while disabled"); // see RULE7
   AST_REF_OFF: assert property (@(posedge clock) disable iff (!arst_n)
      ref_q[`CECFG_BIT_REFDIS] |=> !reference_enable)
      else $error("reference on while disabled"); // see RULE8
   AST_WD_RESTART: assert property (@(posedge clock) disable iff (!arst_n)
      (sreq.wr && sreq.addr == `CECFG_ADDR_WDCTL && sreq.wdata[7]) |=> watchdog_restart)
      else $error("watchdog restart missed"); // see RULE9
   AST_WATCHDOG_OVERFLOW_FLAG_SET: assert property (@(posedge clock) disable iff (!arst_n)
      (watchdog_overflow && external_reset_n) |=> watchdog_overflow_flag_q)
      else $error("overflow flag not set"); // see RULE11
   AST_WATCHDOG_OVERFLOW_FLAG_CLR: assert property (@(posedge clock) disable iff (!arst_n)
      !external_reset_n |=> !watchdog_overflow_flag_q)
      else $error("overflow flag survived external reset"); // see RULE13
   AST_REV_CONST: assert property (@(posedge clock) disable iff (!arst_n)
      (xreq.addr == `CECFG_ADDR_REV) |=> rdata == `CECFG_REVISION)
      else $error("revision read wrong"); // see RULE6
   AST_FUSE_BGB: assert property (@(posedge clock) disable iff (!arst_n)
      (xreq.addr == `CECFG_ADDR_FUSE && fuse_select_q == 8'h06) |=> rdata == {7'h00, $past(bandgap_fuse_b)})
      else $error("fuse readout wrong"); // see RULE4
   AST_SS_RANGE: assert property (@(posedge clock) disable iff (!arst_n)
      ss_active |-> (ss_word_addr >= serial_block_start_addr_q && ss_word_addr <= serial_block_end_addr_q))
      else $error("serial word outside block"); // see RULE1
   AST_TSEL_MONITOR: assert property (@(posedge clock) disable iff (!arst_n)
      (test_output_select_q == 4'h4) |=> test_output_pin == $past(tsrc.realtime_monitor_out))
      else $error("test output not routing monitor"); // see RULE3
   AST_MUX_BOUND: assert property (@(posedge clock) disable iff (!arst_n)
      base_cnt_q < 4'(`CECFG_MUX_PERIODS))
      else $error("mux cycle overran"); // see RULE19
endmodule : cecfg_bank

/* verification/cecfg_bank_bench.sv */
// self-checking bench for the engine configuration register bank
`timescale 1ns/1ps
`include "cecfg_consts.svh"
module cecfg_bank_bench
   import cecfg_pkg::*;
;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic external_reset_n = 1'b1;
   cecfg_xram_req_t xreq = '0;
   cecfg_sfr_req_t sreq = '0;
   logic watchdog_overflow = 1'b0;
   logic battery_flag_in = 1'b0;
   cecfg_tsrc_t tsrc = '0;
   logic [2:0] three_bit_fuse = 3'h0;
   logic bandgap_fuse_a = 1'b0;
   logic bandgap_fuse_b = 1'b0;
   logic ss_word_done = 1'b0;
   logic base_tick = 1'b0;
   logic [7:0] rdata;
   logic rvalid;
   logic test_output_pin;
   logic reference_enable;
   logic reference_to_pin_out;
   logic watchdog_restart;
   logic battery_flag_out;
   logic [3:0] seg_serial_mode;
   logic ss_active;
   logic [7:0] ss_word_addr;
   logic serial_clock_speed_sel;
   logic conv_strobe;
   logic mux_cycle_start;
   cecfg_ce_wr_t ce_wr;
   logic is_high_accuracy;
   int bad_count = 0;
   int total_checks = 0;
   int tick_cnt = 0;
   int gap = 0;
   int convs = 0;
   int mux_gap = 0;
   int conv_seen = 0;

   cecfg_bank i_dut (.clock(clock), .arst_n(arst_n), .external_reset_n(external_reset_n),
      .xreq(xreq), .sreq(sreq), .watchdog_overflow(watchdog_overflow),
      .battery_flag_in(battery_flag_in), .tsrc(tsrc), .three_bit_fuse(three_bit_fuse),
      .bandgap_fuse_a(bandgap_fuse_a), .bandgap_fuse_b(bandgap_fuse_b),
      .ss_word_done(ss_word_done), .base_tick(base_tick), .rdata(rdata), .rvalid(rvalid),
      .test_output_pin(test_output_pin), .reference_enable(reference_enable),
      .reference_to_pin_out(reference_to_pin_out), .watchdog_restart(watchdog_restart),
      .battery_flag_out(battery_flag_out), .seg_serial_mode(seg_serial_mode),
      .ss_active(ss_active), .ss_word_addr(ss_word_addr),
      .serial_clock_speed_sel(serial_clock_speed_sel), .conv_strobe(conv_strobe),
      .mux_cycle_start(mux_cycle_start), .ce_wr(ce_wr), .is_high_accuracy(is_high_accuracy));

   always #5 clock = ~clock;

   // base period pulse every fifth clock
   always @(negedge clock) begin
      tick_cnt = (tick_cnt == 4) ? 0 : tick_cnt + 1;
      base_tick <= (tick_cnt == 0);
   end

   // measures clocks and conversions between mux cycle starts
   always @(negedge clock) begin
      if (mux_cycle_start === 1'b1) begin
         mux_gap = gap;
         conv_seen = convs;
         gap = 0;
         convs = 0;
      end
      gap++;
      if (conv_strobe === 1'b1) convs++;
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_x(input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      xreq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(negedge clock);
      xreq <= '0;
   endtask : wr_x

   task automatic rd_x(input logic [15:0] a, output logic [7:0] d);
      int i;
      @(negedge clock);
      xreq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(negedge clock);
      xreq.rd <= 1'b0;
      for (i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge clock);
      d = rdata;
   endtask : rd_x

   task automatic wr_s(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      sreq <= '{wr: 1'b1, addr: a, wdata: d};
      @(negedge clock);
      sreq <= '0;
   endtask : wr_s

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
      logic [7:0] d;
      rd_x(a, d);
      chk({31'h0, rvalid}, 32'h1);
      chk({24'h0, d & m}, {24'h0, e & m});
   endtask : rd_chk

   task automatic wait_ce;
      int i;
      for (i = 0; i < 4 && ce_wr.ce_word_wr !== 1'b1; i++) @(negedge clock);
      chk({31'h0, ce_wr.ce_word_wr}, 32'h1);
   endtask : wait_ce

   function automatic logic tsel_exp(input logic [3:0] c, input cecfg_tsrc_t s);
      case (c)
         4'h4: return s.realtime_monitor_out;
         4'h9: return s.mux_sync;
         4'ha: return s.ten_mhz_clock;
         4'hb: return s.processor_clock;
         4'hd: return s.rtc_tick_clock;
         4'he: return s.ce_busy;
         default: return s.transfer_busy_event;
      endcase
   endfunction : tsel_exp

   function automatic logic [7:0] pre_val(input logic [1:0] c);
      case (c)
         2'd0: return 8'd42;
         2'd1: return 8'd50;
         2'd2: return 8'd84;
         default: return 8'd100;
      endcase
   endfunction : pre_val

   initial begin
      #200000;
      bad_count++;
      finish_test();
   end

   initial begin
      logic [7:0] v;
      logic [7:0] b [4];
      logic [7:0] n;
      logic [3:0] codes [7];
      int seed;
      int i;
      int k;
      codes = '{4'h4, 4'h9, 4'ha, 4'hb, 4'hd, 4'he, 4'hf};
      seed = $urandom(32'h3eec);
      battery_flag_in = $urandom;
      repeat (4) @(negedge clock);
      arst_n = 1'b1;
      rd_chk(`CECFG_ADDR_SUM, 8'hff, `CECFG_RST_SUM);
      rd_chk(`CECFG_ADDR_STAT, 8'h04, {5'h00, battery_flag_in, 2'b00});
      rd_chk(`CECFG_ADDR_REV, 8'hff, `CECFG_REVISION);
      wr_x(`CECFG_ADDR_REV, ~`CECFG_REVISION);
      rd_chk(`CECFG_ADDR_REV, 8'hff, `CECFG_REVISION);
      for (i = 0; i < 6; i++) begin
         v = $urandom;
         wr_x(`CECFG_ADDR_TSEL, v);
         rd_chk(`CECFG_ADDR_TSEL, 8'h0f, v);
         wr_x(`CECFG_ADDR_SSBEG, v);
         wr_x(`CECFG_ADDR_SSEND, ~v);
         rd_chk(`CECFG_ADDR_SSBEG, 8'hff, v);
         rd_chk(`CECFG_ADDR_SSEND, 8'hff, ~v);
      end
      // fuse selection, codes 4, 5 and 6 three times each, random fuse levels
      for (i = 0; i < 9; i++) begin
         {three_bit_fuse, bandgap_fuse_a, bandgap_fuse_b} = $urandom;
         wr_x(`CECFG_ADDR_FSEL, 8'h04 + (i % 3));
         rd_x(`CECFG_ADDR_FUSE, v);
         case (i % 3)
            0: chk({24'h0, v}, {29'h0, three_bit_fuse});
            1: chk({24'h0, v}, {31'h0, bandgap_fuse_a});
            default: chk({24'h0, v}, {31'h0, bandgap_fuse_b});
         endcase
         chk({31'h0, is_high_accuracy}, {31'h0, bandgap_fuse_b});
      end
      // reference routing and disable
      wr_x(`CECFG_ADDR_REF, 8'h80);
      repeat (3) @(negedge clock);
      chk({30'h0, reference_to_pin_out, reference_enable}, 32'h3);
      wr_x(`CECFG_ADDR_REF, 8'h88);
      repeat (3) @(negedge clock);
      chk({30'h0, reference_to_pin_out, reference_enable}, 32'h0);
      rd_chk(`CECFG_ADDR_REF, 8'h88, 8'h88);
      // test output selector with monitor output enabled
      wr_x(`CECFG_ADDR_STAT, 8'h08);
      for (k = 0; k < 3; k++) begin
         for (i = 0; i < 7; i++) begin
            tsrc = cecfg_tsrc_t'($urandom);
            wr_x(`CECFG_ADDR_TSEL, {4'h0, codes[i]});
            repeat (3) @(negedge clock);
            chk({31'h0, test_output_pin}, {31'h0, tsel_exp(codes[i], tsrc)});
         end
      end
      tsrc = '0;
      // watchdog restart pulse and its absence
      wr_s(`CECFG_ADDR_WDCTL, 8'h00);
      for (i = 0; i < 4; i++) begin
         chk({31'h0, watchdog_restart}, 32'h0);
         @(negedge clock);
      end
      wr_s(`CECFG_ADDR_WDCTL, 8'h80);
      for (i = 0; i < 4 && watchdog_restart !== 1'b1; i++) @(negedge clock);
      chk({31'h0, watchdog_restart}, 32'h1);
      @(negedge clock);
      chk({31'h0, watchdog_restart}, 32'h0);
      // overflow flag: set, software clear, external reset clear
      watchdog_overflow = 1'b1;
      @(negedge clock);
      watchdog_overflow = 1'b0;
      rd_chk(`CECFG_ADDR_STAT, 8'h04, 8'h04);
      chk({31'h0, battery_flag_out}, 32'h1);
      wr_x(`CECFG_ADDR_STAT, 8'h08);
      rd_chk(`CECFG_ADDR_STAT, 8'h04, 8'h00);
      watchdog_overflow = 1'b1;
      @(negedge clock);
      watchdog_overflow = 1'b0;
      external_reset_n = 1'b0;
      repeat (2) @(negedge clock);
      external_reset_n = 1'b1;
      rd_chk(`CECFG_ADDR_STAT, 8'h04, 8'h00);
      // engine word byte mapping
      for (k = 0; k < 5; k++) begin
         n = (k == 0) ? 8'hff : 8'($urandom);
         for (i = 0; i < 4; i++) begin
            b[i] = $urandom;
            wr_x(`CECFG_CE_BASE + {6'h0, n, 2'b00} + 16'(i), b[i]);
         end
         wait_ce();
         chk({24'h0, ce_wr.ce_word_addr}, {24'h0, n});
         chk(ce_wr.ce_word_data, {b[0], b[1], b[2], b[3]});
      end
      // accumulation count mirrored into engine word 36
      for (k = 0; k < 6; k++) begin
         v = (k == 0) ? 8'hff : 8'($urandom);
         wr_x(`CECFG_ADDR_SUM, v);
         wait_ce();
         chk({24'h0, ce_wr.ce_word_addr}, {24'h0, `CECFG_ACC_WORD});
         chk(ce_wr.ce_word_data, {16'h0, 16'(pre_val(v[7:6])) * 16'(v[5:0])});
         rd_chk(`CECFG_ADDR_SUM, 8'hff, v);
      end
      // serial block transfer start through end
      n = 8'($urandom_range(0, 8));
      wr_x(`CECFG_ADDR_SSBEG, n);
      wr_x(`CECFG_ADDR_SSEND, n + 8'h3);
      wr_x(`CECFG_ADDR_SSCTL, 8'hc2);
      repeat (3) @(negedge clock);
      chk({27'h0, serial_clock_speed_sel, seg_serial_mode}, 32'h1f);
      tsrc.ce_busy = 1'b1;
      for (k = 0; k < 4; k++) begin
         for (i = 0; i < 8 && ss_active !== 1'b1; i++) @(negedge clock);
         tsrc.ce_busy = 1'b0;
         chk({24'h0, ss_word_addr}, {24'h0, n + 8'(k)});
         ss_word_done = 1'b1;
         @(negedge clock);
         ss_word_done = 1'b0;
         repeat (2) @(negedge clock);
      end
      repeat (3) @(negedge clock);
      chk({31'h0, ss_active}, 32'h0);
      wr_x(`CECFG_ADDR_SSCTL, 8'h00);
      repeat (3) @(negedge clock);
      chk({28'h0, seg_serial_mode}, 32'h0);
      // mux cycle timing against the base period
      repeat (200) @(negedge clock);
      chk(mux_gap, 32'd65);
      chk(conv_seen, 32'd6);
      finish_test();
   end
endmodule : cecfg_bank_bench
